// File: rtl/fault_params.svh
// constants for the controller fault code manager
// Contract
// RULE_01: power-up self test of os rom, os ram, calendar, processor, program and data memory gives codes 2..7, defect state, 0.4 s blink.
// RULE_02: a watchdog timeout in run gives code 10 and the reset state with the indicator dark, left only by power cycling and a cold restart.
// RULE_03: a corrupt program memory backup at power-up gives code 20, stop, 0.4 s blink and needs a cold restart.
// RULE_04: a faulty memory cartridge program found on entry to run gives code 22, stop, 0.4 s blink, cold restart.
// RULE_05: an abnormal user program found on entry to run gives code 23, stop, 0.4 s blink, cold restart after reload.
// RULE_06: a configured versus fitted module type mismatch on entry to run gives code 30, sets type flags, stop, cold restart.
// RULE_07: a module removed or added while running, seen at scan completion, gives code 31, sets mount flags, stop, 0.4 s blink.
// RULE_08: a blown output fuse seen at scan completion gives code 32, sets fuse flags, stop, cold restart.
// RULE_09: a failed module access at scan completion or during execution gives code 33, sets access flags, stop, 0.4 s blink.
// RULE_10: each module fault class keeps a summary flag, a count of affected slots and a per-slot flag array readable by software.
// RULE_11: the latest error code is readable, the indicator is dark with no error pending, and a cold restart clears the code.
// RULE_12: the defect state refuses every run request until power is removed and reapplied.
`ifndef FAULT_PARAMS_SVH
`define FAULT_PARAMS_SVH

// register byte offsets
`define REG_CODE       8'h00
`define REG_CTRL       8'h04
`define REG_IRQ_STAT   8'h08
`define REG_IRQ_MASK   8'h0c
`define REG_CFG_TYPE   8'h10
`define REG_FLAG_BASE  8'h14
`define REG_FLAG_LAST  8'h20

// control word pulse bits
`define CTRL_RUN_BIT   0
`define CTRL_COLD_BIT  1
`define CTRL_STOP_BIT  2

// code register fields
`define CODE_STATE_LSB 8
`define CODE_TESTED_BIT 12

// flag word fields
`define FLAG_ANY_BIT   16
`define FLAG_CNT_LSB   24

// interrupt status bits
`define IRQ_W          4
`define IRQ_DEFECT     0
`define IRQ_RESET      1
`define IRQ_STOP       2
`define IRQ_MODULE     3

// reset values
`define IRQ_MASK_RST   4'h0
`define CFG_TYPE_RST   32'h0000_0000

// error codes
`define CODE_NONE      8'h00
`define CODE_SELFTEST  8'h02
`define CODE_WDT       8'h0a
`define CODE_BACKUP    8'h14
`define CODE_CART      8'h16
`define CODE_PROG      8'h17
`define CODE_TYPE      8'h1e
`define CODE_MOUNT     8'h1f
`define CODE_FUSE      8'h20
`define CODE_ACCESS    8'h21

// timing
`define CLK_PERIOD_NS  10
`define BLINK_PERIOD_MS 400

`endif

// File: rtl/fault_pkg.sv
// types shared by the fault code manager files
package fault_pkg;

  typedef enum logic [1:0] {
    ST_STOP,
    ST_RUN,
    ST_DEFECT,
    ST_RESET
  } op_state_e;

  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
  } apb_req_s;

  typedef struct packed {
    logic        pready;
    logic        pslverr;
    logic [31:0] prdata;
  } apb_rsp_s;

endpackage : fault_pkg

// File: rtl/slot_fault_tracker.sv
// per-class module fault flags: per slot array, summary flag and slot count
`timescale 1ns/1ps
`default_nettype none
module slot_fault_tracker #(
  parameter int NSLOT = 8,
  parameter int CNT_W = 4
) (
  input  wire logic             clk,
  input  wire logic             rst_n,
  input  wire logic             clear,
  input  wire logic             set_en,
  input  wire logic [NSLOT-1:0] hit,
  output logic      [NSLOT-1:0] per_slot,
  output logic                  any,
  output logic      [CNT_W-1:0] count
);

  typedef struct packed {
    logic [NSLOT-1:0] per;
    logic             any;
    logic [CNT_W-1:0] cnt;
  } trk_s;

  trk_s q;
  trk_s d;

  ////////////////////////////////////////////////////////////////////////////
  // a new hit in the clearing cycle survives the clear
  always_comb begin
    d     = q;
    d.per = (clear ? '0 : q.per) | (set_en ? hit : '0); // [RULE_10]
    d.any = |d.per;
    d.cnt = '0;
    for (int i = 0; i < NSLOT; i++) begin
      d.cnt = d.cnt + CNT_W'(d.per[i]);
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign per_slot = q.per;
  assign any      = q.any;
  assign count    = q.cnt;

endmodule : slot_fault_tracker
`default_nettype wire

// File: rtl/blink_timer.sv
// error indicator blinker, lit for the first half of each period
`timescale 1ns/1ps
`default_nettype none
module blink_timer #(
  parameter int unsigned PERIOD = 40000000
) (
  input  wire logic clk,
  input  wire logic rst_n,
  input  wire logic en,
  output logic      led
);

  localparam int unsigned HALF = (PERIOD / 2 > 0) ? PERIOD / 2 : 1;

  typedef struct packed {
    logic [31:0] cnt;
    logic        phase;
    logic        led;
  } blk_s;

  blk_s q;
  blk_s d;

  ////////////////////////////////////////////////////////////////////////////
  // disabling restarts the period so every new error opens with a lit phase
  always_comb begin
    d = q;
    if (!en) begin
      d.cnt   = '0;
      d.phase = 1'b0;
    end else if (q.cnt == HALF - 1) begin
      d.cnt   = '0;
      d.phase = ~q.phase;
    end else begin
      d.cnt = q.cnt + 32'h1;
    end
    d.led = en & ~d.phase;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign led = q.led;

endmodule : blink_timer
`default_nettype wire

// File: rtl/controller_fault_code_manager.sv
// fault detection, error code and operation state keeper with apb registers
`timescale 1ns/1ps
`default_nettype none
`include "fault_params.svh"
module controller_fault_code_manager
  import fault_pkg::*;
#(
  parameter int          NSLOT  = 8,
  parameter int          TYPE_W = 4,
  parameter int unsigned BLINK_CYCLES = `BLINK_PERIOD_MS * (1000000 / `CLK_PERIOD_NS)
) (
  input  wire logic                    clk,
  input  wire logic                    rst_n,
  input  wire apb_req_s                apb_req,
  output apb_rsp_s                     apb_rsp,
  input  wire logic                    selftest_valid,
  input  wire logic [5:0]              selftest_fail,
  input  wire logic                    backup_bad,
  input  wire logic                    cartridge_fault,
  input  wire logic                    program_fault,
  input  wire logic [NSLOT*TYPE_W-1:0] fitted_type,
  input  wire logic [NSLOT-1:0]        mount_present,
  input  wire logic                    scan_done,
  input  wire logic [NSLOT-1:0]        fuse_blown,
  input  wire logic                    exec_access,
  input  wire logic [NSLOT-1:0]        access_fail,
  input  wire logic                    wdt_timeout,
  output op_state_e                    op_state,
  output logic [7:0]                   err_code,
  output logic                         err_led,
  output logic                         irq
);

  localparam int CNT_W = $clog2(NSLOT + 1);
  localparam int NCLS  = 4; // type, mount, fuse, access

  typedef struct packed {
    op_state_e                state;
    logic                     tested;
    logic [7:0]               code;
    logic [NSLOT-1:0]         snap;
    logic [NSLOT*TYPE_W-1:0]  cfg;
    logic [`IRQ_W-1:0]        stat;
    logic [`IRQ_W-1:0]        mask;
    logic                     irq;
    logic                     pready;
    logic                     pslverr;
    logic [31:0]              prdata;
  } state_s;

  state_s q;
  state_s d;

  logic [NSLOT-1:0]            mism;
  logic [NCLS-1:0][NSLOT-1:0]  cls_hit;
  logic [NCLS-1:0]             cls_set;
  logic [NCLS-1:0][NSLOT-1:0]  trk_per;
  logic [NCLS-1:0]             trk_any;
  logic [NCLS-1:0][CNT_W-1:0]  trk_cnt;
  logic                        blink_en;
  logic                        acc_done;
  logic                        run_go;
  logic                        stop_go;
  logic                        cold_go;
  logic                        mnt_hit;
  logic                        fus_hit;
  logic                        acc_hit;
  logic [`IRQ_W-1:0]           ev;

  ////////////////////////////////////////////////////////////////////////////
  // packs one class of slot flags into a register word
  function automatic logic [31:0] flag_word(input logic [NSLOT-1:0] per,
                                            input logic             any_f,
                                            input logic [CNT_W-1:0] cnt);
    logic [31:0] w;
    w                         = 32'h0;
    w[NSLOT-1:0]              = per;
    w[`FLAG_ANY_BIT]          = any_f;
    w[`FLAG_CNT_LSB +: CNT_W] = cnt;
    return w;
  endfunction : flag_word

  // lowest failing self test item wins the code
  function automatic logic [7:0] selftest_code(input logic [5:0] fail);
    logic [7:0] c;
    c = `CODE_SELFTEST;
    for (int i = 5; i >= 0; i--) begin
      if (fail[i]) begin
        c = `CODE_SELFTEST + 8'(i);
      end
    end
    return c;
  endfunction : selftest_code

  ////////////////////////////////////////////////////////////////////////////
  // per-slot type comparison against the software configured types
  for (genvar s = 0; s < NSLOT; s++) begin : g_type
    assign mism[s] = q.cfg[s*TYPE_W +: TYPE_W] != fitted_type[s*TYPE_W +: TYPE_W]; // [RULE_06]
  end

  // mount changes are measured against the snapshot taken on entry to run
  assign cls_hit[0] = mism;
  assign cls_hit[1] = mount_present ^ q.snap;
  assign cls_hit[2] = fuse_blown;
  assign cls_hit[3] = access_fail;

  // one tracker per fault class
  for (genvar k = 0; k < NCLS; k++) begin : g_cls
    slot_fault_tracker #(
      .NSLOT (NSLOT),
      .CNT_W (CNT_W)
    ) u_trk (
      .clk      (clk),
      .rst_n    (rst_n),
      .clear    (cold_go),
      .set_en   (cls_set[k]),
      .hit      (cls_hit[k]),
      .per_slot (trk_per[k]),
      .any      (trk_any[k]),
      .count    (trk_cnt[k])
    ); // [RULE_10]
  end

  ////////////////////////////////////////////////////////////////////////////
  // indicator blinks in defect and in stop with a code pending, never in reset
  assign blink_en = (q.state == ST_DEFECT) ||
                    ((q.state == ST_STOP) && (q.code != `CODE_NONE)); // [RULE_11]

  blink_timer #(
    .PERIOD (BLINK_CYCLES)
  ) u_blink (
    .clk   (clk),
    .rst_n (rst_n),
    .en    (blink_en),
    .led   (err_led)
  ); // [RULE_01] [RULE_03] [RULE_07] [RULE_09]

  ////////////////////////////////////////////////////////////////////////////
  // bus slave, fault sequencing and interrupt status in one next-state process
  always_comb begin
    d        = q;
    ev       = '0;
    cls_set  = '0;
    mnt_hit  = 1'b0;
    fus_hit  = 1'b0;
    acc_hit  = 1'b0;
    // pready rises one cycle into the access phase; writes land at its edge
    acc_done = apb_req.psel & apb_req.penable & q.pready;
    d.pready = apb_req.psel & apb_req.penable & ~q.pready;
    run_go   = 1'b0;
    stop_go  = 1'b0;
    cold_go  = 1'b0;
    if (acc_done && apb_req.pwrite) begin
      unique case (apb_req.paddr)
        `REG_CTRL: begin
          run_go  = apb_req.pwdata[`CTRL_RUN_BIT];
          cold_go = apb_req.pwdata[`CTRL_COLD_BIT] && (q.state == ST_STOP);
          stop_go = apb_req.pwdata[`CTRL_STOP_BIT];
        end
        `REG_IRQ_MASK: d.mask = apb_req.pwdata[`IRQ_W-1:0];
        `REG_CFG_TYPE: d.cfg  = apb_req.pwdata[NSLOT*TYPE_W-1:0];
        default: ;
      endcase
    end
    // read data is captured with pready so it is stable for the whole beat
    if (!q.pready && apb_req.psel && apb_req.penable) begin
      d.prdata  = 32'h0;
      d.pslverr = 1'b0;
      if (apb_req.paddr == `REG_CODE) begin
        d.prdata[7:0]                   = q.code; // [RULE_11]
        d.prdata[`CODE_STATE_LSB +: 2]  = q.state;
        d.prdata[`CODE_TESTED_BIT]      = q.tested;
      end else if (apb_req.paddr == `REG_CTRL) begin
        d.prdata = 32'h0;
      end else if (apb_req.paddr == `REG_IRQ_STAT) begin
        d.prdata[`IRQ_W-1:0] = q.stat;
      end else if (apb_req.paddr == `REG_IRQ_MASK) begin
        d.prdata[`IRQ_W-1:0] = q.mask;
      end else if (apb_req.paddr == `REG_CFG_TYPE) begin
        d.prdata[NSLOT*TYPE_W-1:0] = q.cfg;
      end else if (apb_req.paddr >= `REG_FLAG_BASE && apb_req.paddr <= `REG_FLAG_LAST &&
                   apb_req.paddr[1:0] == 2'h0) begin
        for (int k = 0; k < NCLS; k++) begin
          if (apb_req.paddr == `REG_FLAG_BASE + 8'(4 * k)) begin
            d.prdata = flag_word(trk_per[k], trk_any[k], trk_cnt[k]); // [RULE_10]
          end
        end
      end else begin
        d.pslverr = 1'b1;
      end
    end

    // power-up self test result is taken once
    if (selftest_valid && !q.tested) begin
      d.tested = 1'b1;
      if (|selftest_fail) begin
        d.state       = ST_DEFECT; // [RULE_01]
        d.code        = selftest_code(selftest_fail);
        ev[`IRQ_DEFECT] = 1'b1;
      end else if (backup_bad) begin
        d.state       = ST_STOP; // [RULE_03]
        d.code        = `CODE_BACKUP;
        ev[`IRQ_STOP] = 1'b1;
      end
    end else begin
      unique case (q.state)
        ST_STOP: begin
          if (cold_go) begin
            d.code = `CODE_NONE; // [RULE_11]
          end else if (run_go && q.tested && q.code == `CODE_NONE) begin
            // run entry checks, cartridge first, then program, then types
            if (cartridge_fault) begin
              d.code        = `CODE_CART; // [RULE_04]
              ev[`IRQ_STOP] = 1'b1;
            end else if (program_fault) begin
              d.code        = `CODE_PROG; // [RULE_05]
              ev[`IRQ_STOP] = 1'b1;
            end else if (|mism) begin
              d.code          = `CODE_TYPE; // [RULE_06]
              cls_set[0]      = 1'b1;
              ev[`IRQ_MODULE] = 1'b1;
            end else begin
              d.state = ST_RUN;
              d.snap  = mount_present;
            end
          end
        end
        ST_RUN: begin
          if (wdt_timeout) begin
            d.state        = ST_RESET; // [RULE_02]
            d.code         = `CODE_WDT;
            ev[`IRQ_RESET] = 1'b1;
          end else begin
            mnt_hit    = scan_done && (mount_present != q.snap); // [RULE_07]
            fus_hit    = scan_done && (|fuse_blown); // [RULE_08]
            acc_hit    = (scan_done || exec_access) && (|access_fail); // [RULE_09]
            cls_set[1] = mnt_hit;
            cls_set[2] = fus_hit;
            cls_set[3] = acc_hit;
            if (mnt_hit || fus_hit || acc_hit) begin
              d.state         = ST_STOP;
              d.code          = mnt_hit ? `CODE_MOUNT : (fus_hit ? `CODE_FUSE : `CODE_ACCESS);
              ev[`IRQ_MODULE] = 1'b1;
            end else if (stop_go) begin
              d.state = ST_STOP;
            end
          end
        end
        // both are left only through the power-on reset
        ST_DEFECT: ; // [RULE_12]
        ST_RESET: ; // [RULE_02]
      endcase
    end

    // read clears only the bits it returned, so a new event is never lost
    d.stat = q.stat;
    if (acc_done && !apb_req.pwrite && apb_req.paddr == `REG_IRQ_STAT) begin
      d.stat = q.stat & ~q.prdata[`IRQ_W-1:0];
    end
    d.stat = d.stat | ev;
    d.irq  = |(d.stat & d.mask);
  end

  // reset loads constants only; mask and type table take their own reset words
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      q      <= '0;
      q.mask <= `IRQ_MASK_RST;
      q.cfg  <= `CFG_TYPE_RST;
    end else begin
      q <= d;
    end
  end

  assign op_state = q.state;
  assign err_code = q.code;
  assign irq      = q.irq;
  assign apb_rsp  = '{pready: q.pready, pslverr: q.pslverr, prdata: q.prdata};

  ////////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  sequence s_run_check;
    (q.state == ST_STOP) && run_go && q.tested && (q.code == `CODE_NONE) &&
    !(selftest_valid && !q.tested) && !cold_go;
  endsequence

  sequence s_running;
    (q.state == ST_RUN) && !wdt_timeout;
  endsequence

  a_selftest_defect: assert property (selftest_valid && !q.tested && selftest_fail[0]
      |=> op_state == ST_DEFECT && err_code == 8'h02) // [RULE_01]
    else $error("self test failure did not give defect with code 2");
  a_wdt_reset: assert property ((q.state == ST_RUN) && wdt_timeout
      |=> op_state == ST_RESET && err_code == 8'h0a ##1 !err_led) // [RULE_02]
    else $error("watchdog did not enter reset with dark indicator");
  a_backup_stop: assert property (selftest_valid && !q.tested && !(|selftest_fail) && backup_bad
      |=> op_state == ST_STOP && err_code == 8'h14 ##1 err_led) // [RULE_03]
    else $error("backup error not reported");
  a_cart_stop: assert property (s_run_check ##0 cartridge_fault
      |=> op_state == ST_STOP && err_code == 8'h16) // [RULE_04]
    else $error("cartridge fault not reported");
  a_prog_stop: assert property (s_run_check ##0 (!cartridge_fault && program_fault)
      |=> op_state == ST_STOP && err_code == 8'h17) // [RULE_05]
    else $error("program fault not reported");
  a_type_flags: assert property (s_run_check ##0 (!cartridge_fault && !program_fault && |mism)
      |=> err_code == 8'h1e && trk_any[0] && op_state == ST_STOP) // [RULE_06]
    else $error("type mismatch not reported");
  a_mount_flags: assert property (s_running ##0 (scan_done && mount_present != q.snap)
      |=> err_code == 8'h1f && trk_any[1] && op_state == ST_STOP) // [RULE_07]
    else $error("mount change not reported");
  a_fuse_flags: assert property (s_running ##0 (scan_done && |fuse_blown)
      |=> trk_any[2] && op_state == ST_STOP) // [RULE_08]
    else $error("fuse fault not flagged");
  a_access_exec: assert property (s_running ##0 (exec_access && |access_fail && !scan_done)
      |=> err_code == 8'h21 && trk_any[3]) // [RULE_09]
    else $error("access fault during execution not reported");
  a_any_count: assert property ((trk_any[1] == |trk_per[1]) &&
      (trk_cnt[1] == CNT_W'($countones(trk_per[1])))) // [RULE_10]
    else $error("summary flag or count disagrees with slot array");
  a_cold_clear: assert property ((q.state == ST_STOP) && cold_go && !(selftest_valid && !q.tested)
      |=> err_code == 8'h00 ##1 !err_led) // [RULE_11]
    else $error("cold restart did not clear code and indicator");
  a_defect_sticky: assert property (op_state == ST_DEFECT |=> op_state == ST_DEFECT) // [RULE_12]
    else $error("defect state was left");

  // a pending code must be cleared by a cold restart before run is granted
  a_run_refused: assert property ((q.state == ST_STOP) && run_go && !cold_go &&
      (q.code != `CODE_NONE) && !(selftest_valid && !q.tested)
      |=> op_state == ST_STOP && $stable(err_code)) // [RULE_03]
    else $error("run granted with an error code pending");

  // dark in the reset state and whenever nothing is pending outside defect
  a_led_dark: assert property ((q.state == ST_RESET) ||
      ((q.state != ST_DEFECT) && (q.code == `CODE_NONE)) |=> !err_led) // [RULE_11]
    else $error("indicator lit with nothing pending");

endmodule : controller_fault_code_manager
`default_nettype wire

// File: bench/io_base_model.sv
// behavioural model of the i/o and special modules fitted on the base
`timescale 1ns/1ps
`default_nettype none
module io_base_model #(
  parameter int NSLOT  = 8,
  parameter int TYPE_W = 4
) (
  output logic [NSLOT*TYPE_W-1:0] fitted_type,
  output logic [NSLOT-1:0]        mount_present,
  output logic [NSLOT-1:0]        fuse_blown,
  output logic [NSLOT-1:0]        access_fail
);
  // every slot starts fitted with type 0 and healthy
  initial begin
    fitted_type   = '0;
    mount_present = '1;
    fuse_blown    = '0;
    access_fail   = '0;
  end
  // bench commands, applied by nba so they land after the edge that launched them
  task fit(input int s, input logic [TYPE_W-1:0] t);
    fitted_type[s*TYPE_W +: TYPE_W] <= t;
  endtask : fit
  task mount(input int s, input logic v);
    mount_present[s] <= v;
  endtask : mount
  task fuse(input int s, input logic v);
    fuse_blown[s] <= v;
  endtask : fuse
  // a failing module keeps failing every access until healed
  task fail(input int s, input logic v);
    access_fail[s] <= v;
  endtask : fail
endmodule : io_base_model
`default_nettype wire

// File: bench/controller_fault_code_manager_tb.sv
// self-checking bench for the fault code manager
`timescale 1ns/1ps
`default_nettype none
`include "fault_params.svh"
module controller_fault_code_manager_tb import fault_pkg::*;;
  localparam int NSLOT = 8;
  localparam int TYPE_W = 4;
  localparam int BLINK = 8;
  logic                    clk;
  logic                    rst_n;
  apb_req_s                req;
  apb_rsp_s                rsp;
  logic                    selftest_valid;
  logic [5:0]              selftest_fail;
  logic                    backup_bad;
  logic                    cartridge_fault;
  logic                    program_fault;
  logic [NSLOT*TYPE_W-1:0] fitted_type;
  logic [NSLOT-1:0]        mount_present;
  logic                    scan_done;
  logic [NSLOT-1:0]        fuse_blown;
  logic                    exec_access;
  logic [NSLOT-1:0]        access_fail;
  logic                    wdt_timeout;
  op_state_e               op_state;
  logic [7:0]              err_code;
  logic                    err_led;
  logic                    irq;
  int                      num_errors;
  int                      comparisons;
  int                      cyc;
  logic [31:0]             rd;
  logic                    er;

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  controller_fault_code_manager #(.NSLOT(NSLOT), .TYPE_W(TYPE_W), .BLINK_CYCLES(BLINK))
    i_controller_fault_code_manager (.clk(clk), .rst_n(rst_n), .apb_req(req), .apb_rsp(rsp),
    .selftest_valid(selftest_valid), .selftest_fail(selftest_fail), .backup_bad(backup_bad),
    .cartridge_fault(cartridge_fault), .program_fault(program_fault),
    .fitted_type(fitted_type), .mount_present(mount_present), .scan_done(scan_done),
    .fuse_blown(fuse_blown), .exec_access(exec_access), .access_fail(access_fail),
    .wdt_timeout(wdt_timeout), .op_state(op_state), .err_code(err_code),
    .err_led(err_led), .irq(irq));

  io_base_model #(.NSLOT(NSLOT), .TYPE_W(TYPE_W)) i_io_base_model (
    .fitted_type(fitted_type), .mount_present(mount_present),
    .fuse_blown(fuse_blown), .access_fail(access_fail));

  ////////////////////////////////////////////////////////////////////////////////
  task close_out;
    $display("errors %0d comparisons %0d", num_errors, comparisons);
    if (num_errors == 0 && comparisons > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : close_out

  // a hung handshake ends the run here
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      num_errors++;
      close_out();
    end
  end

  task chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      num_errors++;
      $display("unexpected %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  // apb master: hold the request until pready is seen at an edge
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    req <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: d};
    @(posedge clk);
    req.penable <= 1'b1;
    do @(posedge clk); while (rsp.pready !== 1'b1);
    rd = rsp.prdata;
    er = rsp.pslverr;
    req <= '0;
  endtask : apb

  // two edges cover the one-edge effect latency, then look mid-cycle
  task settle;
    repeat (2) @(posedge clk);
    @(negedge clk);
  endtask : settle

  task reg_chk(input string what, input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(what, rd, exp);
  endtask : reg_chk

  task ctrl(input logic [31:0] d);
    apb(1'b1, `REG_CTRL, d);
    settle();
  endtask : ctrl

  task state(input op_state_e s, input logic [7:0] c);
    chk("op_state", {30'h0, op_state}, {30'h0, s});
    chk("err_code", {24'h0, err_code}, {24'h0, c});
  endtask : state

  // lit samples over one blink period
  task blink(input logic [31:0] exp);
    int n;
    n = 0;
    repeat (BLINK) begin
      @(negedge clk);
      if (err_led === 1'b1) n++;
    end
    chk("blink lit count", n, exp);
  endtask : blink

  task pulse(input logic [2:0] p);
    @(posedge clk);
    {wdt_timeout, exec_access, scan_done} <= p;
    @(posedge clk);
    {wdt_timeout, exec_access, scan_done} <= 3'b0;
    settle();
  endtask : pulse

  task self_test(input logic [5:0] f, input logic b);
    @(posedge clk);
    selftest_fail <= f;
    backup_bad <= b;
    selftest_valid <= 1'b1;
    @(posedge clk);
    selftest_valid <= 1'b0;
    settle();
  endtask : self_test

  // power cycle: a defect or reset state is left only this way
  task power_up;
    rst_n <= 1'b0;
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
  endtask : power_up

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    rst_n = 1'b0;
    req = '0;
    {selftest_valid, backup_bad, cartridge_fault, program_fault} = 4'h0;
    selftest_fail = 6'h00;
    {wdt_timeout, exec_access, scan_done} = 3'b0;
    power_up();
    reg_chk("irq mask reset", `REG_IRQ_MASK, 32'h0);
    reg_chk("cfg type reset", `REG_CFG_TYPE, 32'h0);
    apb(1'b0, 8'h40, 32'h0);
    chk("unmapped error", {31'h0, er}, 32'h1);
    state(ST_STOP, `CODE_NONE);
    chk("idle led", {31'h0, err_led}, 32'h0);
    // each self-test source, one power cycle apiece
    for (int k = 0; k < 6; k++) begin
      power_up();
      self_test(6'(1 << k), 1'b0);
      state(ST_DEFECT, `CODE_SELFTEST + 8'(k));
      blink(32'd4);
      ctrl(32'h3);
      state(ST_DEFECT, `CODE_SELFTEST + 8'(k));
    end
    power_up();
    self_test(6'h00, 1'b1);
    state(ST_STOP, `CODE_BACKUP);
    blink(32'd4);
    reg_chk("code reg", `REG_CODE, 32'h0000_1014);
    chk("irq masked", {31'h0, irq}, 32'h0);
    apb(1'b1, `REG_IRQ_MASK, 32'h4);
    settle();
    chk("irq raised", {31'h0, irq}, 32'h1);
    reg_chk("irq stat", `REG_IRQ_STAT, 32'h4);
    settle();
    chk("irq cleared", {31'h0, irq}, 32'h0);
    reg_chk("irq stat again", `REG_IRQ_STAT, 32'h0);
    ctrl(32'h1);
    state(ST_STOP, `CODE_BACKUP);
    ctrl(32'h2);
    state(ST_STOP, `CODE_NONE);
    chk("led after cold", {31'h0, err_led}, 32'h0);
    // run entry checks of cartridge and user program
    for (int i = 0; i < 2; i++) begin
      @(posedge clk);
      cartridge_fault <= (i == 0);
      program_fault <= (i == 1);
      ctrl(32'h1);
      state(ST_STOP, (i == 0) ? `CODE_CART : `CODE_PROG);
      @(posedge clk);
      {cartridge_fault, program_fault} <= 2'b00;
      ctrl(32'h2);
    end
    i_io_base_model.fit(3, 4'h5);
    ctrl(32'h1);
    state(ST_STOP, `CODE_TYPE);
    reg_chk("type flags", `REG_FLAG_BASE, 32'h0101_0008);
    apb(1'b1, `REG_CFG_TYPE, 32'h0000_5000);
    ctrl(32'h2);
    reg_chk("type flags cleared", `REG_FLAG_BASE, 32'h0);
    ctrl(32'h1);
    state(ST_RUN, `CODE_NONE);
    i_io_base_model.mount(5, 1'b0);
    pulse(3'b001);
    state(ST_STOP, `CODE_MOUNT);
    blink(32'd4);
    reg_chk("mount flags", `REG_FLAG_BASE + 8'h04, 32'h0101_0020);
    i_io_base_model.mount(5, 1'b1);
    ctrl(32'h2);
    ctrl(32'h1);
    i_io_base_model.fuse(1, 1'b1);
    i_io_base_model.fuse(2, 1'b1);
    pulse(3'b001);
    state(ST_STOP, `CODE_FUSE);
    reg_chk("fuse flags", `REG_FLAG_BASE + 8'h08, 32'h0201_0006);
    i_io_base_model.fuse(1, 1'b0);
    i_io_base_model.fuse(2, 1'b0);
    ctrl(32'h2);
    ctrl(32'h1);
    i_io_base_model.fail(0, 1'b1);
    pulse(3'b010);
    state(ST_STOP, `CODE_ACCESS);
    reg_chk("access flags", `REG_FLAG_BASE + 8'h0c, 32'h0101_0001);
    ctrl(32'h2);
    ctrl(32'h1);
    pulse(3'b001);
    state(ST_STOP, `CODE_ACCESS);
    i_io_base_model.fail(0, 1'b0);
    ctrl(32'h2);
    ctrl(32'h1);
    ctrl(32'h4);
    state(ST_STOP, `CODE_NONE);
    ctrl(32'h1);
    pulse(3'b100);
    state(ST_RESET, `CODE_WDT);
    blink(32'd0);
    ctrl(32'h3);
    state(ST_RESET, `CODE_WDT);
    close_out();
  end
endmodule : controller_fault_code_manager_tb
`default_nettype wire
